/* File: design/asdp_framer.sv */
// descriptor builder driven by apb registers, emitting a byte stream
//
// The implementer's own choices: the address map and the APB slave port.
`include "asdp_cfg.svh"
`default_nettype none
module asdp_framer (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    output asdp_pkg::asdp_byte_t      ds_out,
    input  wire logic                 ds_ready
);
    import asdp_pkg::*;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup_w   = psel & ~penable;
    wire logic access_w  = psel & penable;
    wire logic hit_ctrl  = (paddr == `ASDP_REG_CTRL);
    wire logic hit_f0    = (paddr == `ASDP_REG_FIELDS0);
    wire logic hit_f1    = (paddr == `ASDP_REG_FIELDS1);
    wire logic hit_end   = (paddr == `ASDP_REG_END);
    wire logic hit_stat  = (paddr == `ASDP_REG_STATUS);
    wire logic hit_text  = (paddr == `ASDP_REG_TEXT);
    wire logic mapped_w  = hit_ctrl | hit_f0 | hit_f1 | hit_end | hit_stat | hit_text;
    wire logic wr_w      = access_w & pwrite & mapped_w;
    wire logic start_w   = wr_w & hit_ctrl & pwdata[`ASDP_CTRL_START_BIT];

    assign pready  = 1'b1;
    assign pslverr = access_w & ~mapped_w;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    asdp_fields0_t f0_q;
    asdp_fields1_t f1_q;
    logic [2:0]    end_q;
    logic          err_q;
    logic          done_q;
    logic [7:0]    len_q;
    logic [31:0]   prdata_q;
    asdp_state_t   st_q;
    asdp_state_t   st_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f0_q  <= '0;
            f1_q  <= '0;
            end_q <= `ASDP_END_EXT;
        end else if (wr_w) begin
            if (hit_f0) begin
                f0_q <= asdp_fields0_t'(pwdata);
            end
            if (hit_f1) begin
                f1_q <= asdp_fields1_t'(pwdata);
            end
            if (hit_end) begin
                end_q <= pwdata[2:0];
            end
        end
    end

    wire logic ram_we_w = wr_w & hit_text;

    // ------------------------------------------------------------
    // legality of the programmed fields
    // ------------------------------------------------------------
    wire logic bad_sr_w   = (f0_q.srate == `ASDP_SR_RESERVED);
    wire logic bad_rate_w = (f0_q.rate_code[4:0] > `ASDP_RATE_IDX_MAX);
    wire logic bad_sur_w  = (f0_q.surround == `ASDP_SUR_RESERVED);
    wire logic bad_ch_w   = (f0_q.chan_cfg >= `ASDP_CH_RES_MIN);
    wire logic bad_txt_w  = ~f1_q.charset & f1_q.text_len[0];
    wire logic bad_end_w  = (end_q > `ASDP_END_EXT);

    // dual mono is the all-zero code, so the second language byte follows it
    wire logic dual_w     = (f0_q.chan_cfg == 4'h0);
    wire logic assoc_w    = (f0_q.svc_mode >= `ASDP_SVC_ASSOC_MIN);

    // ------------------------------------------------------------
    // declared length
    // ------------------------------------------------------------
    wire logic inc_rate_w = (end_q >= `ASDP_END_RATE);
    wire logic inc_svc_w  = (end_q >= `ASDP_END_SVC);
    wire logic inc_lang_w = (end_q >= `ASDP_END_LANG);
    wire logic inc_id_w   = (end_q >= `ASDP_END_ID);
    wire logic inc_text_w = (end_q >= `ASDP_END_TEXT);
    wire logic inc_ext_w  = (end_q >= `ASDP_END_EXT);

    wire logic [8:0] len_w = 9'h001
                           + {8'h00, inc_rate_w}
                           + {8'h00, inc_svc_w}
                           + {8'h00, inc_lang_w}
                           + {8'h00, inc_lang_w & dual_w}
                           + {8'h00, inc_id_w}
                           + (inc_text_w ? {1'b0, f1_q.text_len} + 9'h001 : 9'h000)
                           + (inc_ext_w ? {1'b0, f1_q.ext_cnt} : 9'h000);
    wire logic bad_len_w  = (len_w > `ASDP_LEN_MAX);

    wire logic cfg_bad_w  = bad_sr_w | bad_rate_w | bad_sur_w | bad_ch_w | bad_txt_w | bad_end_w | bad_len_w;
    wire logic idle_w     = (st_q == ST_IDLE);
    wire logic go_w       = start_w & idle_w & ~cfg_bad_w;

    // ------------------------------------------------------------
    // byte sequencer
    // ------------------------------------------------------------
    logic [6:0] txt_idx_q;
    logic [6:0] txt_idx_d;
    logic [7:0] ext_idx_q;
    logic [7:0] ext_idx_d;
    logic [7:0] ram_rdata;
    asdp_byte_t out_q;

    wire logic adv_w = ~idle_w & (~out_q.valid | ds_ready);

    // stage that follows the id byte, or the end of the descriptor
    wire asdp_state_t after_id_w   = inc_text_w ? ST_TLEN : ST_IDLE;
    wire asdp_state_t after_lang_w = inc_id_w ? ST_ID : ST_IDLE;
    wire logic        text_more_w  = (txt_idx_q != f1_q.text_len - 7'h01);
    wire logic        ext_more_w   = (ext_idx_q != f1_q.ext_cnt - 8'h01);
    wire asdp_state_t after_text_w = (inc_ext_w && (f1_q.ext_cnt != 8'h00)) ? ST_EXT : ST_IDLE;

    always_comb begin
        st_d      = st_q;
        txt_idx_d = txt_idx_q;
        ext_idx_d = ext_idx_q;
        if (go_w) begin
            st_d      = ST_TAG;
            txt_idx_d = 7'h00;
            ext_idx_d = 8'h00;
        end else if (adv_w) begin
            unique case (st_q)
                ST_IDLE:  st_d = ST_IDLE;
                ST_TAG:   st_d = ST_LEN;
                ST_LEN:   st_d = ST_SR;
                ST_SR:    st_d = inc_rate_w ? ST_RATE : ST_IDLE;
                ST_RATE:  st_d = inc_svc_w ? ST_SVC : ST_IDLE;
                ST_SVC:   st_d = inc_lang_w ? ST_LANG : ST_IDLE;
                ST_LANG:  st_d = dual_w ? ST_LANG2 : after_lang_w;
                ST_LANG2: st_d = after_lang_w;
                ST_ID:    st_d = after_id_w;
                ST_TLEN:  st_d = (f1_q.text_len != 7'h00) ? ST_TEXT : after_text_w;
                ST_TEXT: begin
                    st_d      = text_more_w ? ST_TEXT : after_text_w;
                    txt_idx_d = txt_idx_q + 7'h01;
                end
                ST_EXT: begin
                    st_d      = ext_more_w ? ST_EXT : ST_IDLE;
                    ext_idx_d = ext_idx_q + 8'h01;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // byte contents per stage
    // ------------------------------------------------------------
    logic [7:0] byte_w;

    always_comb begin
        byte_w = 8'h00;
        unique case (st_q)
            ST_IDLE:  byte_w = 8'h00;
            ST_TAG:   byte_w = `ASDP_TAG;
            ST_LEN:   byte_w = len_q;
            ST_SR:    byte_w = {f0_q.srate, f0_q.version};
            ST_RATE:  byte_w = {f0_q.rate_code, f0_q.surround};
            ST_SVC:   byte_w = {f0_q.svc_mode, f0_q.chan_cfg, f0_q.full_svc};
            ST_LANG:  byte_w = f0_q.lang;
            ST_LANG2: byte_w = f1_q.lang2;
            ST_ID:    byte_w = assoc_w ? f1_q.id_byte
                                       : {f1_q.id_byte[2:0], `ASDP_ID_RESERVED};
            ST_TLEN:  byte_w = {f1_q.text_len, f1_q.charset};
            ST_TEXT:  byte_w = ram_rdata;
            ST_EXT:   byte_w = `ASDP_EXT_FILL;
        endcase
    end

    wire logic last_w = adv_w & (st_d == ST_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= ST_IDLE;
            txt_idx_q <= 7'h00;
            ext_idx_q <= 8'h00;
        end else begin
            st_q      <= st_d;
            txt_idx_q <= txt_idx_d;
            ext_idx_q <= ext_idx_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else if (adv_w) begin
            out_q.valid <= 1'b1;
            out_q.first <= (st_q == ST_TAG);
            out_q.last  <= last_w;
            out_q.data  <= byte_w;
        end else if (ds_ready) begin
            out_q.valid <= 1'b0;
        end
    end

    assign ds_out = out_q;

    // ------------------------------------------------------------
    // status and length capture
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_q  <= 8'h00;
            err_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (start_w & idle_w) begin
                err_q  <= cfg_bad_w;
                done_q <= 1'b0;
            end else if (last_w) begin
                done_q <= 1'b1;
            end
            if (go_w) begin
                len_q <= len_w[7:0];
            end
        end
    end

    wire logic [31:0] stat_w = {16'h0000, len_q, 5'h00, done_q, err_q, ~idle_w};

    wire logic [31:0] rd_mux_w = hit_f0   ? 32'(f0_q)
                               : hit_f1   ? 32'(f1_q)
                               : hit_end  ? {29'h0, end_q}
                               : hit_stat ? stat_w
                               : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_w & ~pwrite) begin
            prdata_q <= rd_mux_w;
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // text store
    // ------------------------------------------------------------
    asdp_text_ram u_text (
        .pclk    (pclk),
        .we      (ram_we_w),
        .waddr   (pwdata[6:0]),
        .wdata   (pwdata[15:8]),
        .raddr   (txt_idx_d),
        .rdata_q (ram_rdata)
    );

endmodule : asdp_framer
`default_nettype wire

/* File: design/asdp_text_ram.sv */
// text byte store with registered read data
`default_nettype none
module asdp_text_ram (
    input  wire logic       pclk,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [6:0] raddr,
    output logic      [7:0] rdata_q
);
    logic [7:0] mem [0:127];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : asdp_text_ram
`default_nettype wire

/* File: shared/asdp_cfg.svh */
// constants of the audio stream descriptor framer
`ifndef ASDP_CFG_SVH
`define ASDP_CFG_SVH

`define ASDP_TAG            8'h81
`define ASDP_REG_CTRL       12'h000
`define ASDP_REG_FIELDS0    12'h004
`define ASDP_REG_FIELDS1    12'h008
`define ASDP_REG_END        12'h00c
`define ASDP_REG_STATUS     12'h010
`define ASDP_REG_TEXT       12'h014
`define ASDP_CTRL_START_BIT 0
`define ASDP_SR_RESERVED    3'h3
`define ASDP_RATE_IDX_MAX   5'h12
`define ASDP_SUR_RESERVED   2'h3
`define ASDP_CH_RES_MIN     4'he
`define ASDP_SVC_ASSOC_MIN  3'h2
`define ASDP_ID_RESERVED    5'h1f
`define ASDP_EXT_FILL       8'h00
`define ASDP_LEN_MAX        9'h0ff
`define ASDP_END_SR         3'h0
`define ASDP_END_RATE       3'h1
`define ASDP_END_SVC        3'h2
`define ASDP_END_LANG       3'h3
`define ASDP_END_ID         3'h4
`define ASDP_END_TEXT       3'h5
`define ASDP_END_EXT        3'h6
`define ASDP_TEXT_DEPTH     128

`endif

/* File: shared/asdp_pkg.sv */
// types of the audio stream descriptor framer
`default_nettype none
package asdp_pkg;

    typedef struct packed {
        logic [7:0] lang;
        logic       full_svc;
        logic [3:0] chan_cfg;
        logic [2:0] svc_mode;
        logic [1:0] surround;
        logic [5:0] rate_code;
        logic [4:0] version;
        logic [2:0] srate;
    } asdp_fields0_t;

    typedef struct packed {
        logic [7:0] ext_cnt;
        logic       charset;
        logic [6:0] text_len;
        logic [7:0] id_byte;
        logic [7:0] lang2;
    } asdp_fields1_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } asdp_byte_t;

    typedef enum logic [11:0] {
        ST_IDLE  = 12'h001,
        ST_TAG   = 12'h002,
        ST_LEN   = 12'h004,
        ST_SR    = 12'h008,
        ST_RATE  = 12'h010,
        ST_SVC   = 12'h020,
        ST_LANG  = 12'h040,
        ST_LANG2 = 12'h080,
        ST_ID    = 12'h100,
        ST_TLEN  = 12'h200,
        ST_TEXT  = 12'h400,
        ST_EXT   = 12'h800
    } asdp_state_t;

endpackage : asdp_pkg
`default_nettype wire

/* File: verif/asdp_checker.sv */
// checker of the descriptor byte stream
`default_nettype none
module asdp_checker (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire asdp_pkg::asdp_byte_t ds_out,
    input wire logic                 ds_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    import asdp_pkg::*;
    // ----
    // byte position tracking
    // ----
    logic [8:0] pos_q;
    logic [7:0] len_q;
    wire take = ds_out.valid && ds_ready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 9'h000;
            len_q <= 8'h00;
        end else if (take) begin
            pos_q <= ds_out.first ? 9'h001 : pos_q + 9'h001;
            if (!ds_out.first && pos_q == 9'h001) begin
                len_q <= ds_out.data;
            end
        end
    end
    property p_tag; ds_out.valid && ds_out.first |-> ds_out.data == 8'h81; endproperty
    property p_len; take && ds_out.last |-> pos_q - 9'h001 == {1'b0, len_q}; endproperty
    property p_srate; take && !ds_out.first && pos_q == 9'h002 |-> ds_out.data[7:5] != 3'h3; endproperty
    property p_rate; take && !ds_out.first && pos_q == 9'h003 |-> ds_out.data[6:2] <= 5'h12; endproperty
    property p_sur; take && !ds_out.first && pos_q == 9'h003 |-> ds_out.data[1:0] != 2'h3; endproperty
    property p_chan; take && !ds_out.first && pos_q == 9'h004 |-> ds_out.data[4:1] < 4'he; endproperty
    property p_hold; ds_out.valid && !ds_ready |=> ds_out.valid && $stable(ds_out); endproperty
    property p_frame; take && ds_out.last |=> !ds_out.valid || ds_out.first; endproperty
    a_tag: assert property (p_tag) else $error("tag byte wrong");
    a_len: assert property (p_len) else $error("byte count differs from length");
    a_srate: assert property (p_srate) else $error("reserved sample rate sent");
    a_rate: assert property (p_rate) else $error("rate index above 18");
    a_sur: assert property (p_sur) else $error("reserved surround sent");
    a_chan: assert property (p_chan) else $error("reserved channel code sent");
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    a_frame: assert property (p_frame) else $error("byte after last byte");
    c_first: cover property (take && ds_out.first);
    c_stall: cover property (ds_out.valid && !ds_ready);
    c_long: cover property (take && ds_out.last && pos_q > 9'h008);
    c_err: cover property (pslverr);
endmodule : asdp_checker
bind asdp_framer asdp_checker asdp_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ds_out(ds_out), .ds_ready(ds_ready));
`default_nettype wire

/* File: verif/asdp_sink.sv */
// demultiplexer side model taking descriptor bytes
`default_nettype none
module asdp_sink (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire asdp_pkg::asdp_byte_t ds_out,
    input wire logic                 slow,
    output logic                     ds_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    import asdp_pkg::*;
    // ----
    // byte capture with optional stalls
    // ----
    logic [1:0] cnt_q;
    logic [7:0] got[$];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            ds_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            ds_ready <= !slow || cnt_q == 2'h2; // one byte per strobe, stalls when slow
            if (ds_out.valid && ds_ready) begin
                got.push_back(ds_out.data); // every byte up to the length kept, extension too
            end
        end
    end
endmodule : asdp_sink
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench of the descriptor framer
`include "asdp_cfg.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import asdp_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, r, prdata;
    logic pready, pslverr, ds_ready;
    asdp_byte_t ds_out;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    logic [31:0] bad [4] = '{32'h113b5243, 32'h113b5340, 32'h113bd240, 32'h11735240};
    logic [34:0] bad1 [3] = '{{3'h6, 32'hffff0000}, {3'h5, 32'h00010000}, {3'h7, 32'h0000a6ee}};
    always #10 pclk = ~pclk;
    asdp_framer asdp_framer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ds_out(ds_out),
        .ds_ready(ds_ready));
    asdp_sink asdp_sink_i (.pclk(pclk), .presetn(presetn), .ds_out(ds_out), .slow(slow), .ds_ready(ds_ready));
    // ----
    // tasks
    // ----
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task run(input logic [31:0] f0, input logic [31:0] f1, input logic [2:0] n, input logic s);
        logic [7:0] q[$];
        int i;
        slow <= s;
        asdp_sink_i.got.delete();
        apb(1'b1, `ASDP_REG_FIELDS0, f0);
        apb(1'b1, `ASDP_REG_FIELDS1, f1);
        apb(1'b1, `ASDP_REG_END, {29'h0, n});
        for (i = 0; i < int'(f1[22:16]); i++) apb(1'b1, `ASDP_REG_TEXT, {16'h0, 8'h41 + 8'(i), 1'b0, 7'(i)});
        apb(1'b1, `ASDP_REG_CTRL, 32'h1);
        i = 0;
        do begin
            apb(1'b0, `ASDP_REG_STATUS, 32'h0);
            i++;
        end while (r[2] !== 1'b1 && i < 300);
        chk({31'h0, r[2]}, 32'h1);
        q = '{8'h81, 8'h00, {f0[2:0], f0[7:3]}};
        if (n >= 1) q.push_back({f0[13:8], f0[15:14]});
        if (n >= 2) q.push_back({f0[18:16], f0[22:19], f0[23]});
        if (n >= 3) q.push_back(f0[31:24]);
        if (n >= 3 && f0[22:19] == 4'h0) q.push_back(f1[7:0]);
        if (n >= 4) q.push_back(f0[18:16] < 3'h2 ? {f1[10:8], 5'h1f} : f1[15:8]);
        if (n >= 5) q.push_back({f1[22:16], f1[23]});
        for (i = 0; n >= 5 && i < int'(f1[22:16]); i++) q.push_back(8'h41 + 8'(i));
        for (i = 0; n == 6 && i < int'(f1[31:24]); i++) q.push_back(8'h00);
        q[1] = 8'(q.size() - 2);
        chk({24'h0, r[15:8]}, {24'h0, q[1]});
        for (i = 0; i < 40 && asdp_sink_i.got.size() < q.size(); i++) @(posedge pclk);
        chk(asdp_sink_i.got.size(), q.size());
        foreach (q[k]) chk({24'h0, asdp_sink_i.got[k]}, {24'h0, q[k]});
        apb(1'b0, `ASDP_REG_STATUS, 32'h0);
        chk({30'h0, r[1:0]}, 32'h0);
    endtask : run
    // ----
    // main sequence
    // ----
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ASDP_REG_STATUS, 32'h0);
        chk({29'h0, r[2:0]}, 32'h0);
        apb(1'b0, `ASDP_REG_END, 32'h0);
        chk({29'h0, r[2:0]}, 32'h6);
        apb(1'b0, 12'h0ff, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        run(32'h5a81b245, 32'h0283053c, 3'h6, 1'b1);
        run(32'h113b5240, 32'h0000a6ee, 3'h4, 1'b0);
        run(32'h22ef0047, 32'h05028000, 3'h5, 1'b1);
        run(32'h113b5240, 32'h0000a6ee, 3'h0, 1'b0);
        run(32'h5a81b245, 32'h0283053c, 3'h3, 1'b0);
        run(32'h22ef0047, 32'h05028000, 3'h2, 1'b0);
        run(32'h22ef0047, 32'h05028000, 3'h1, 1'b1);
        foreach (bad[k]) begin
            asdp_sink_i.got.delete();
            apb(1'b1, `ASDP_REG_FIELDS0, bad[k]);
            apb(1'b1, `ASDP_REG_CTRL, 32'h1);
            apb(1'b0, `ASDP_REG_STATUS, 32'h0);
            chk({31'h0, r[1]}, 32'h1);
            chk(asdp_sink_i.got.size(), 32'h0);
        end
        apb(1'b1, `ASDP_REG_FIELDS0, 32'h113b5240);
        foreach (bad1[k]) begin
            asdp_sink_i.got.delete();
            apb(1'b1, `ASDP_REG_FIELDS1, bad1[k][31:0]);
            apb(1'b1, `ASDP_REG_END, {29'h0, bad1[k][34:32]});
            apb(1'b1, `ASDP_REG_CTRL, 32'h1);
            apb(1'b0, `ASDP_REG_STATUS, 32'h0);
            chk({31'h0, r[1]}, 32'h1);
            chk(asdp_sink_i.got.size(), 32'h0);
        end
        give_verdict;
    end
endmodule : testbench
`default_nettype wire
